/* rtl/tpo_pkg.sv */
// constants shared by the timer control/flag block and its prescaler
// assumes an 8-bit register port with byte offsets as listed here
package tpo_pkg;
    // register offsets (byte addresses on the register port)
    localparam logic [7:0] ADDR_COUNT_HI     = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LO     = 8'h05;
    localparam logic [7:0] ADDR_CH_IRQ_EN    = 8'h0c;
    localparam logic [7:0] ADDR_CTRL_TWO     = 8'h0d;
    localparam logic [7:0] ADDR_CH_FLAGS     = 8'h0e;
    localparam logic [7:0] ADDR_OVF_FLAGS    = 8'h0f;
    localparam logic [7:0] ADDR_CH7_CMP_HI   = 8'h1e;
    localparam logic [7:0] ADDR_CH7_CMP_LO   = 8'h1f;
    // channel register window, upper nibble of the address
    localparam logic [3:0] CH_WINDOW_NIBBLE  = 4'h1;

    // field positions in timer_control_two and overflow_flag_register
    localparam int OVF_IRQ_EN_BIT            = 7;
    localparam int RESET_ON_MATCH7_BIT       = 3;
    localparam int PRESCALE_SEL_MSB          = 2;
    localparam int OVF_FLAG_BIT              = 7;

    // reset values, and the all-ones count that marks an overflow
    localparam logic [7:0]  CTRL_TWO_RESET   = 8'h00;
    localparam logic [7:0]  CH_FLAGS_RESET   = 8'h00;
    localparam logic [7:0]  CH_IRQ_EN_RESET  = 8'h00;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [15:0] CH7_CMP_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES   = 16'hffff;

    // prescaler: 3-bit select, divide by 2**select, up to 128
    localparam int          PRESCALE_WIDTH   = 7;
    localparam logic [6:0]  PRESCALE_RESET   = 7'h00;
    localparam logic [2:0]  PRESCALE_SEL_RESET = 3'h0;
endpackage

/* rtl/tpo_presc_if.sv */
// prescaler control and tick between the timer core and its divider
// assumes both ends run on the same bus clock
`timescale 1ns/100ps
`default_nettype none
interface tpo_presc_if;
    logic       run;        // timer enabled, divider counts
    logic       restart;    // counter reset by match, divider back to zero
    logic [2:0] select;     // select as written by software
    logic       tick;       // one-cycle timer clock enable
    logic [2:0] active_sel; // select actually in use

    modport core (output run, output restart, output select, input tick, input active_sel);
    modport presc (input run, input restart, input select, output tick, output active_sel);
endinterface
`default_nettype wire

/* rtl/tpo_prescaler.sv */
// bus clock prescaler making the timer clock enable pulse
// assumes the synchronous reset copy and enables from the timer core
`timescale 1ns/100ps
`default_nettype none
module tpo_prescaler (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // link to the timer core
    tpo_presc_if.presc pif
);
    logic [tpo_pkg::PRESCALE_WIDTH-1:0] stage;
    logic [tpo_pkg::PRESCALE_WIDTH-1:0] stage_mask;

    // stages below the active select must all be ones for a tick
    assign stage_mask = 7'((8'h01 << pif.active_sel) - 8'h01);

    // divider stages; restart keeps the match period at n*div plus one clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage <= tpo_pkg::PRESCALE_RESET;
        end else if (pif.restart || !pif.run) begin
            stage <= tpo_pkg::PRESCALE_RESET;
        end else begin
            stage <= stage + 7'h01;
        end
    end

    // new select is adopted only where every stage is zero, no short period
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pif.active_sel <= tpo_pkg::PRESCALE_SEL_RESET;
        end else if (stage == tpo_pkg::PRESCALE_RESET) begin
            pif.active_sel <= pif.select;
        end
    end

    // divide by 2**select of the bus clock
    assign pif.tick = pif.run && !pif.restart
                      && ((stage & stage_mask) == stage_mask);
endmodule
`default_nettype wire

/* rtl/tpo_timer.sv */
// timer control and flags: prescaler select, counter, match-7 reset, flags, irq
// assumes one bus clock; channel events and enables come from sibling blocks
`timescale 1ns/100ps
`default_nettype none
module tpo_timer (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic [7:0]       rd_data_out,
    // enables kept in neighbouring control registers
    input  wire logic        timer_enable_bit_in,
    input  wire logic        pulse_accum_enable_in,
    input  wire logic        fast_flag_clear_enable_in,
    // channel side
    input  wire logic [7:0]  ch_event_in,
    input  wire logic [7:0]  ch_is_compare_in,
    output logic             match7_out,
    output logic [15:0]      free_running_count_out,
    // interrupt
    output logic             irq_out
);
    tpo_presc_if pif ();

    logic        rst_sync1;
    logic        rst_sync_n;
    logic [7:0]  timer_control_two;
    logic [7:0]  channel_irq_enable;
    logic [7:0]  channel_event_flags;
    logic        overflow_flag;
    logic [15:0] free_running_count;
    logic [15:0] channel7_compare_value;
    logic        count_moved;
    logic        do_reset;
    logic        match7_event;
    logic        rollover;
    logic        flag_clear_ok;
    logic        ch_window;
    logic [2:0]  ch_index;
    logic [7:0]  ch_fast_clear;
    logic [7:0]  ch_w1c;
    logic [7:0]  ch_set;
    logic        count_access;
    logic        ovf_clear;
    logic [7:0]  next_rd_data;
    logic        overflow_irq_enable;
    logic        counter_reset_on_match7;

    // reset released through two flops; the first flop feeds only the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync1  <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_sync1  <= 1'b1;
            rst_sync_n <= rst_sync1;
        end
    end

    tpo_prescaler u_presc (
        .clk_in   (clk_in),
        .rst_n_in (rst_sync_n),
        .pif      (pif.presc)
    );

    assign overflow_irq_enable     = timer_control_two[tpo_pkg::OVF_IRQ_EN_BIT];
    assign counter_reset_on_match7 = timer_control_two[tpo_pkg::RESET_ON_MATCH7_BIT];

    assign pif.run     = timer_enable_bit_in;
    assign pif.select  = timer_control_two[tpo_pkg::PRESCALE_SEL_MSB:0];
    assign pif.restart = do_reset;

    // reset on match wins over a tick; held at zero when compare value is zero
    assign do_reset = timer_enable_bit_in && counter_reset_on_match7
                      && (free_running_count == channel7_compare_value);

    // a compare event fires in the first cycle the count holds the value, every cycle while match reset holds it at zero
    assign match7_event = count_moved && (free_running_count == channel7_compare_value);

    // wrap only by ticking past all ones; a match reset is no overflow
    assign rollover = pif.tick && !do_reset
                      && (free_running_count == tpo_pkg::COUNT_ALL_ONES);

    // free-running counter
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            free_running_count <= tpo_pkg::COUNT_RESET;
            count_moved        <= 1'b0;
        end else if (do_reset) begin
            free_running_count <= tpo_pkg::COUNT_RESET;
            count_moved        <= 1'b1;
        end else if (pif.tick) begin
            free_running_count <= free_running_count + 16'h0001;
            count_moved        <= 1'b1;
        end else begin
            count_moved        <= 1'b0;
        end
    end

    // register decode helpers
    assign ch_window    = (addr_in[7:4] == tpo_pkg::CH_WINDOW_NIBBLE);
    assign ch_index     = addr_in[3:1];
    assign count_access = (rd_en_in || wr_en_in)
                          && ((addr_in == tpo_pkg::ADDR_COUNT_HI)
                              || (addr_in == tpo_pkg::ADDR_COUNT_LO));
    assign flag_clear_ok = timer_enable_bit_in || pulse_accum_enable_in;

    // per channel: fast clear by capture read or compare write, and set sources
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_ch
            assign ch_fast_clear[ch] = fast_flag_clear_enable_in && ch_window
                && (ch_index == 3'(ch))
                && ((rd_en_in && !ch_is_compare_in[ch])
                    || (wr_en_in && ch_is_compare_in[ch]));
            assign ch_w1c[ch] = wr_en_in && flag_clear_ok
                && (addr_in == tpo_pkg::ADDR_CH_FLAGS) && wr_data_in[ch];
            if (ch == 7) begin : g_seven
                assign ch_set[ch] = ch_event_in[ch]
                    || (match7_event && ch_is_compare_in[ch]);
            end else begin : g_other
                assign ch_set[ch] = ch_event_in[ch];
            end
        end
    endgenerate

    // channel flags: set beats clear so an event in the clear cycle survives
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            channel_event_flags <= tpo_pkg::CH_FLAGS_RESET;
        end else begin
            channel_event_flags <= (channel_event_flags & ~(ch_w1c | ch_fast_clear))
                                   | ch_set;
        end
    end

    // overflow flag: write one while active, or any counter access in fast mode
    assign ovf_clear = (wr_en_in && flag_clear_ok
                        && (addr_in == tpo_pkg::ADDR_OVF_FLAGS)
                        && wr_data_in[tpo_pkg::OVF_FLAG_BIT])
                       || (fast_flag_clear_enable_in && count_access);

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            overflow_flag <= 1'b0;
        end else if (rollover) begin
            overflow_flag <= 1'b1;
        end else if (ovf_clear) begin
            overflow_flag <= 1'b0;
        end
    end

    // software-written control registers
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_control_two  <= tpo_pkg::CTRL_TWO_RESET;
            channel_irq_enable <= tpo_pkg::CH_IRQ_EN_RESET;
        end else if (wr_en_in) begin
            if (addr_in == tpo_pkg::ADDR_CTRL_TWO) begin
                timer_control_two <= wr_data_in & 8'h8f; // bits 6:4 unused
            end
            if (addr_in == tpo_pkg::ADDR_CH_IRQ_EN) begin
                channel_irq_enable <= wr_data_in;
            end
        end
    end

    // channel 7 compare value, written byte by byte
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            channel7_compare_value <= tpo_pkg::CH7_CMP_RESET;
        end else if (wr_en_in && addr_in == tpo_pkg::ADDR_CH7_CMP_HI) begin
            channel7_compare_value[15:8] <= wr_data_in;
        end else if (wr_en_in && addr_in == tpo_pkg::ADDR_CH7_CMP_LO) begin
            channel7_compare_value[7:0] <= wr_data_in;
        end
    end

    // read mux; unmapped addresses and other channel registers read zero
    always_comb begin
        next_rd_data = 8'h00;
        case (addr_in)
            tpo_pkg::ADDR_COUNT_HI:   next_rd_data = free_running_count[15:8];
            tpo_pkg::ADDR_COUNT_LO:   next_rd_data = free_running_count[7:0];
            tpo_pkg::ADDR_CH_IRQ_EN:  next_rd_data = channel_irq_enable;
            tpo_pkg::ADDR_CTRL_TWO:   next_rd_data = timer_control_two;
            tpo_pkg::ADDR_CH_FLAGS:   next_rd_data = channel_event_flags;
            tpo_pkg::ADDR_OVF_FLAGS:  next_rd_data = {overflow_flag, 7'h00};
            tpo_pkg::ADDR_CH7_CMP_HI: next_rd_data = channel7_compare_value[15:8];
            tpo_pkg::ADDR_CH7_CMP_LO: next_rd_data = channel7_compare_value[7:0];
            default:                  next_rd_data = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_out <= next_rd_data;
        end else begin
            rd_data_out <= 8'h00;
        end
    end

    // level interrupt from any enabled flag
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (|(channel_event_flags & channel_irq_enable))
                       || (overflow_flag && overflow_irq_enable);
        end
    end

    // registered copies for the channel logic next door
    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            match7_out             <= 1'b0;
            free_running_count_out <= tpo_pkg::COUNT_RESET;
        end else begin
            match7_out             <= match7_event;
            free_running_count_out <= free_running_count;
        end
    end
endmodule
`default_nettype wire

/* verif/tpo_timer_chk.sv */
// port assertions for the timer control and flag block
// assumes binding onto tpo_timer; reads answer in the next cycle only
`timescale 1ns/100ps
`default_nettype none
module tpo_timer_chk (
    // watched ports
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [7:0]  wr_data_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic        timer_enable_bit_in,
    input wire logic        pulse_accum_enable_in,
    input wire logic [7:0]  ch_event_in,
    input wire logic [15:0] free_running_count_out,
    input wire logic        irq_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic rd_fl;
    logic wr_fl;
    // flag register strobes, shared by several properties
    assign rd_fl = rd_en_in && addr_in == tpo_pkg::ADDR_CH_FLAGS;
    assign wr_fl = wr_en_in && addr_in == tpo_pkg::ADDR_CH_FLAGS;
    a_count_step: assert property (
        $changed(free_running_count_out) |-> free_running_count_out == 16'h0000
        || free_running_count_out == $past(free_running_count_out) + 16'h0001)
        else $error("counter moved by other than one");
    // pipeline from enable to count output is short, five idle cycles cover it
    a_count_idle: assert property (
        (!timer_enable_bit_in)[*5] |=> $stable(free_running_count_out))
        else $error("counter ran while timer disabled");
    a_read_idle: assert property (!rd_en_in |=> rd_data_out == 8'h00)
        else $error("read data outside read cycle");
    a_ctrl_readback: assert property (
        wr_en_in && addr_in == tpo_pkg::ADDR_CTRL_TWO ##1 rd_en_in
        && addr_in == tpo_pkg::ADDR_CTRL_TWO |=> rd_data_out == ($past(wr_data_in, 2) & 8'h8f))
        else $error("control two readback wrong");
    a_flag_clear: assert property (
        wr_fl && wr_data_in == 8'hff && (timer_enable_bit_in || pulse_accum_enable_in)
        && ch_event_in == 8'h00 ##1 rd_fl && ch_event_in == 8'h00 |=> rd_data_out[6:0] == 7'h00)
        else $error("flags survived write one");
    a_set_beats_clear: assert property (
        wr_fl && ch_event_in != 8'h00 ##1 rd_fl
        |=> (rd_data_out & $past(ch_event_in, 2)) == $past(ch_event_in, 2))
        else $error("clear beat simultaneous set");
    a_event_sets_flag: assert property (
        ch_event_in != 8'h00 ##1 rd_fl
        |=> (rd_data_out & $past(ch_event_in, 2)) == $past(ch_event_in, 2))
        else $error("event did not set flag");
    a_ovf_unused_zero: assert property (
        rd_en_in && addr_in == tpo_pkg::ADDR_OVF_FLAGS |=> rd_data_out[6:0] == 7'h00)
        else $error("unused overflow bits set");
    cover property ($rose(irq_out));
    cover property (free_running_count_out == 16'hffff);
    cover property (wr_fl ##1 rd_fl);
endmodule
bind tpo_timer tpo_timer_chk u_chk (.clk_in, .rst_n_in, .addr_in, .wr_data_in, .wr_en_in,
    .rd_en_in, .rd_data_out, .timer_enable_bit_in, .pulse_accum_enable_in, .ch_event_in,
    .free_running_count_out, .irq_out);
`default_nettype wire

/* verif/tpo_timer_tb.sv */
// self-checking bench for the timer control and flag block
// assumes tpo_timer ports as declared; every input driven here at rising edges
`timescale 1ns/100ps
`default_nettype none
module tpo_timer_tb;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdat = 8'h00;
    logic        wen = 1'b0;
    logic        ren = 1'b0;
    logic        timer_on = 1'b0;
    logic        accum_on = 1'b0;
    logic        ffca = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic [7:0]  cmpm = 8'h00;
    logic [7:0]  rdat;
    logic        m7;
    logic [15:0] cnt;
    logic [15:0] p;
    logic        irq;
    logic [7:0]  v;
    int          n;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // 4 ns bus clock
    always #2 clk_in = ~clk_in;
    tpo_timer DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wdat),
        .wr_en_in(wen), .rd_en_in(ren), .rd_data_out(rdat), .timer_enable_bit_in(timer_on),
        .pulse_accum_enable_in(accum_on), .fast_flag_clear_enable_in(ffca), .ch_event_in(ev),
        .ch_is_compare_in(cmpm), .match7_out(m7), .free_running_count_out(cnt), .irq_out(irq));
    task automatic end_of_test();
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read data is sampled mid-cycle, clear of the edge that drops it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        ren <= 1'b1;
        @(posedge clk_in);
        ren <= 1'b0;
        @(negedge clk_in);
        d = rdat;
        @(posedge clk_in);
    endtask
    // write followed at once by a read, no idle cycle between
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        addr <= a;
        wdat <= d;
        wen <= 1'b1;
        @(posedge clk_in);
        wen <= 1'b0;
        rd(a, q);
    endtask
    // trailing idle cycle keeps the strobe from being set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdat <= d;
        wen <= 1'b1;
        @(posedge clk_in);
        wen <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic pulse(input logic [7:0] m);
        ev <= m;
        @(posedge clk_in);
        ev <= 8'h00;
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        check(irq, e);
        @(posedge clk_in);
    endtask
    // cycles between two counter changes, or two arrivals at zero when z is set
    task automatic span(input logic z, output int c);
        int e;
        int t;
        e = 0;
        c = 0;
        t = 0;
        @(negedge clk_in);
        p = cnt;
        while (e < 2 && t < 2000) begin
            @(negedge clk_in);
            t++;
            if (e == 1) c++;
            if (z ? (p !== 16'h0000 && cnt === 16'h0000) : (cnt !== p)) e++;
            p = cnt;
        end
        @(posedge clk_in);
    endtask
    task automatic t_regs();
        logic [7:0] ra [7] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h1e, 8'h1f, 8'h30};
        foreach (ra[i]) begin
            rd(ra[i], v);
            check(v, 8'h00);
        end
    endtask
    // full rollover at divide one, the longest part of the run
    task automatic t_ovf();
        timer_on <= 1'b1;
        wr(8'h0d, 8'h80);
        n = 0;
        while (cnt !== 16'hffff && n < 70000) begin
            @(negedge clk_in);
            n++;
        end
        repeat (4) @(posedge clk_in);
        rd(8'h0f, v);
        check(v, 8'h80);
        chk_irq(1'b1);
        wr(8'h0d, 8'h00);
        chk_irq(1'b0);
        timer_on <= 1'b0;
        wr(8'h0f, 8'h80);
        rd(8'h0f, v);
        check(v, 8'h80);
        timer_on <= 1'b1;
        ffca <= 1'b1;
        rd(8'h05, v);
        rd(8'h0f, v);
        check(v, 8'h00);
        ffca <= 1'b0;
    endtask
    task automatic t_presc();
        for (int s = 0; s < 8; s++) begin
            wr_rd(8'h0d, 8'(s), v);
            check(v, 8'(s));
            // the new select waits for the free-running stages to pass zero
            repeat (130) @(posedge clk_in);
            span(1'b0, n);
            span(1'b0, n);
            check(n, 1 << s);
        end
        wr(8'h0d, 8'h00);
        n = 0;
        p = cnt;
        while (cnt === p && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        check(n > 100, 1'b1);
        @(posedge clk_in);
    endtask
    task automatic t_flags();
        timer_on <= 1'b0;
        pulse(8'h5a);
        rd(8'h0e, v);
        check(v, 8'h5a);
        wr(8'h0e, 8'hff);
        rd(8'h0e, v);
        check(v, 8'h5a);
        accum_on <= 1'b1;
        wr(8'h0e, 8'h00);
        rd(8'h0e, v);
        check(v, 8'h5a);
        wr_rd(8'h0e, 8'hff, v);
        check(v, 8'h00);
        wr(8'h0c, 8'h02);
        pulse(8'h02);
        chk_irq(1'b1);
        wr(8'h0c, 8'hfd);
        chk_irq(1'b0);
        addr <= 8'h0e;
        wdat <= 8'hff;
        wen <= 1'b1;
        ev <= 8'h08;
        @(posedge clk_in);
        wen <= 1'b0;
        ev <= 8'h00;
        rd(8'h0e, v);
        check(v, 8'h08);
        wr(8'h0e, 8'hff);
        wr(8'h0c, 8'h00);
    endtask
    task automatic t_fast();
        ffca <= 1'b1;
        cmpm <= 8'h20;
        pulse(8'h24);
        rd(8'h14, v);
        rd(8'h0e, v);
        check(v, 8'h20);
        wr(8'h1a, 8'h00);
        rd(8'h0e, v);
        check(v, 8'h00);
        ffca <= 1'b0;
        cmpm <= 8'h00;
    endtask
    // mid-run reset brings the count below the compare value, else no match for a whole wrap
    task automatic t_match();
        cmpm <= 8'h80;
        rst_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        wr(8'h1f, 8'h05);
        wr(8'h0d, 8'h09);
        timer_on <= 1'b1;
        span(1'b1, n);
        check(n, 11);
        // match pulse is one cycle wide, looked at mid-cycle
        n = 0;
        @(negedge clk_in);
        while (m7 !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        check(m7, 1'b1);
        @(negedge clk_in);
        check(m7, 1'b0);
        @(posedge clk_in);
        rd(8'h0e, v);
        check(v, 8'h80);
        wr(8'h0d, 8'h0f);
        span(1'b1, n);
        check(n, 641);
        wr(8'h1f, 8'h00);
        repeat (300) @(posedge clk_in);
        @(negedge clk_in);
        check(cnt, 16'h0000);
    endtask
    // hang guard well above the expected length of the run
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_regs();
        t_ovf();
        t_presc();
        t_flags();
        t_fast();
        t_match();
        end_of_test();
    end
endmodule
`default_nettype wire
